// [verilog/smc_map.vh]
// constants and register layout of the standby mode controller
// Behaviour
// - interrupts raised during flag or mask register access wait for that instruction's end
// - halt gates the processor clock; the oscillator keeps running
// - stop halts the main oscillator; all internally clocked operation ceases
// - standby keeps registers, flags, memory, port latches and buffers unchanged
// - select codes 000, 010, 100 give 2^12, 2^15, 2^17 waits; others prohibited
// - reset loads select register 04h but the post-reset wait is 2^15
// - wait counting starts only once the oscillator actually runs
// - port output latches hold their halt-entry state throughout halt
// - timer a counts in stop only when fed by running timer b
// - timer b counts in stop only when its external input is selected
// - serial interface stops in stop unless externally clocked
// - halt keeps external interrupts only for unmasked maskable sources
// - unmasked interrupt ends halt; vectored if enabled, else next instruction
// - non-vectored halt release resumes within one to two processor clocks
// - non-maskable interrupt ends halt and is always vectored
// - stop release waits for oscillator stabilisation before resuming
// - reset during halt abandons halt and goes to the reset vector
// - stop release by interrupt vectors only after the wait, if enabled
// - a pending unmasked flag at standby entry releases standby at once
`ifndef SMC_MAP_VH
`define SMC_MAP_VH
`define SMC_OSC_STAB_TIME_SELECT_ADDR     16'hfffa
`define SMC_OSC_STAB_TIME_SELECT_RESET    3'h4
`define SMC_SEL_MSB       2
`define SMC_SEL_2P12      3'h0
`define SMC_SEL_2P15      3'h2
`define SMC_SEL_2P17      3'h4
`define SMC_WAIT_2P12     18'h01000
`define SMC_WAIT_2P15     18'h08000
`define SMC_WAIT_2P17     18'h20000
`define SMC_HALT_RESUME   2'h1
`endif

// [verilog/smc_stab_counter.v]
// oscillator stabilisation wait counter
`default_nettype none
`include "smc_map.vh"
module smc_stab_counter (
  input  wire        ref_clk_in,
  input  wire        rst_n_in,
  input  wire        start_in,
  input  wire        osc_running_in,
  input  wire [17:0] length_in,
  output reg         busy_out,
  output reg         done_out
);
  // -----------------------------------------------------------
  // counting
  // -----------------------------------------------------------
  reg [17:0] count;
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count    <= 18'h00000;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        count    <= 18'h00000;
        busy_out <= 1'b1;
      end else if (busy_out && osc_running_in) begin
        if (count == length_in - 18'h00001) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count <= count + 18'h00001;
        end
      end
    end
  end
endmodule // smc_stab_counter
`default_nettype wire

// [verilog/smc_standby_ctrl.v]
// standby mode controller: halt, stop, stabilisation wait, interrupt hold
`default_nettype none
`include "smc_map.vh"
module smc_standby_ctrl (
  input  wire        ref_clk_in,
  input  wire        rst_n_in,
  // register access from the core
  input  wire [15:0] addr_in,
  input  wire [7:0]  wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [7:0]  rdata_out,
  // instruction and interrupt status from the core
  input  wire        halt_instr_in,
  input  wire        stop_instr_in,
  input  wire        flag_access_in,
  input  wire        instr_end_in,
  input  wire        irq_unmasked_in,
  input  wire        nmi_in,
  input  wire        global_irq_enable_in,
  input  wire        osc_running_in,
  // peripheral clock selections
  input  wire        timer_a_src_timer_b_in,
  input  wire        timer_b_running_in,
  input  wire        timer_b_ext_sel_in,
  input  wire        serial_ext_clk_in,
  // control outputs
  output wire        cpu_clk_en_out,
  output wire        osc_enable_out,
  output wire        latch_hold_out,
  output wire        irq_ack_allow_out,
  output wire        ext_irq_enable_out,
  output wire        timer_a_run_out,
  output wire        timer_b_run_out,
  output wire        serial_run_out,
  output reg         resume_next_out,
  output reg         vector_irq_out,
  output wire        in_halt_out,
  output wire        in_stop_out,
  output wire        in_wait_out
);
  // -----------------------------------------------------------
  // states
  // -----------------------------------------------------------
  localparam [2:0] ST_RESET_WAIT = 3'h0;
  localparam [2:0] ST_RUN        = 3'h1;
  localparam [2:0] ST_HALT       = 3'h2;
  localparam [2:0] ST_STOP       = 3'h3;
  localparam [2:0] ST_STOP_WAIT  = 3'h4;
  localparam [2:0] ST_RESUME     = 3'h5;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [2:0]  stab_sel;
  reg         after_reset;
  reg         pend_vec;
  reg         next_pend_vec;
  reg  [1:0]  resume_cnt;
  reg         cnt_start;
  reg         reset_started;
  wire        reset_kick;
  wire        cnt_busy;
  wire        cnt_done;
  wire [17:0] wait_len;

  // -----------------------------------------------------------
  // wait length decode
  // -----------------------------------------------------------
  function [17:0] sel_to_len;
    input [2:0] sel;
    begin
      case (sel)
        `SMC_SEL_2P12: sel_to_len = `SMC_WAIT_2P12;
        `SMC_SEL_2P15: sel_to_len = `SMC_WAIT_2P15;
        `SMC_SEL_2P17: sel_to_len = `SMC_WAIT_2P17;
        default:       sel_to_len = `SMC_WAIT_2P17;
      endcase
    end
  endfunction

  // first wait after reset is 2^15 despite the 04h reset code
  assign wait_len = after_reset ? `SMC_WAIT_2P15 :
                    sel_to_len(stab_sel);

  // -----------------------------------------------------------
  // stabilisation select register
  // -----------------------------------------------------------
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stab_sel <= `SMC_OSC_STAB_TIME_SELECT_RESET;
    end else if (wr_in && addr_in == `SMC_OSC_STAB_TIME_SELECT_ADDR) begin
      stab_sel <= wdata_in[`SMC_SEL_MSB:0];
    end
  end

  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in && addr_in == `SMC_OSC_STAB_TIME_SELECT_ADDR) begin
      rdata_out <= {5'h00, stab_sel};
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // -----------------------------------------------------------
  // stabilisation counter
  // -----------------------------------------------------------
  smc_stab_counter u_cnt (
    .ref_clk_in     (ref_clk_in),
    .rst_n_in       (rst_n_in),
    .start_in       (cnt_start),
    .osc_running_in (osc_running_in),
    .length_in      (wait_len),
    .busy_out       (cnt_busy),
    .done_out       (cnt_done)
  );

  // -----------------------------------------------------------
  // next state
  // -----------------------------------------------------------
  always @* begin
    next_state    = state;
    next_pend_vec = pend_vec;
    cnt_start     = 1'b0;
    case (state)
      ST_RESET_WAIT: begin
        cnt_start = reset_kick;
        if (cnt_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_pend_vec = 1'b0;
        if (stop_instr_in) begin
          next_state = ST_STOP;
        end else if (halt_instr_in) begin
          next_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (nmi_in) begin
          next_pend_vec = 1'b1;
          next_state    = ST_RESUME;
        end else if (irq_unmasked_in) begin
          next_pend_vec = global_irq_enable_in;
          next_state    = ST_RESUME;
        end
      end
      ST_STOP: begin
        if (irq_unmasked_in) begin
          next_pend_vec = global_irq_enable_in;
          cnt_start     = 1'b1;
          next_state    = ST_STOP_WAIT;
        end
      end
      ST_STOP_WAIT: begin
        if (cnt_done) begin
          next_state = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (resume_cnt == `SMC_HALT_RESUME) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // -----------------------------------------------------------
  // state register
  // -----------------------------------------------------------
  // reset from any mode lands here; halt is abandoned
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state      <= ST_RESET_WAIT;
      pend_vec   <= 1'b0;
      resume_cnt <= 2'h0;
    end else begin
      state    <= next_state;
      pend_vec <= next_pend_vec;
      if (state == ST_RESUME) begin
        resume_cnt <= resume_cnt + 2'h1;
      end else begin
        resume_cnt <= 2'h0;
      end
    end
  end

  // post-reset wait runs once, started by the first clock after release
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      after_reset <= 1'b1;
    end else if (state == ST_STOP_WAIT || (state == ST_RUN)) begin
      after_reset <= 1'b0;
    end
  end

  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reset_started <= 1'b0;
    end else begin
      reset_started <= 1'b1;
    end
  end
  assign reset_kick = !reset_started;

  // -----------------------------------------------------------
  // resume strobes
  // -----------------------------------------------------------
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resume_next_out <= 1'b0;
      vector_irq_out  <= 1'b0;
    end else begin
      resume_next_out <= (state == ST_RESUME) && (next_state == ST_RUN)
                         && !pend_vec;
      vector_irq_out  <= (state == ST_RESUME) && (next_state == ST_RUN)
                         && pend_vec;
    end
  end

  // -----------------------------------------------------------
  // control outputs
  // -----------------------------------------------------------
  wire standby = (state == ST_HALT) || (state == ST_STOP) ||
                 (state == ST_STOP_WAIT);
  wire osc_off = (state == ST_STOP);

  assign cpu_clk_en_out     = (state == ST_RUN);
  assign osc_enable_out     = !osc_off;
  assign latch_hold_out     = standby || (state == ST_RESUME);
  assign irq_ack_allow_out  = (state == ST_RUN) && !flag_access_in;
  assign ext_irq_enable_out = !standby || irq_unmasked_in;
  assign timer_a_run_out    = !osc_off ||
                              (timer_a_src_timer_b_in &&
                               timer_b_running_in);
  assign timer_b_run_out    = !osc_off || timer_b_ext_sel_in;
  assign serial_run_out     = !osc_off || serial_ext_clk_in;
  assign in_halt_out        = (state == ST_HALT);
  assign in_stop_out        = (state == ST_STOP);
  assign in_wait_out        = cnt_busy || (state == ST_RESET_WAIT);

  // instruction end is not needed: flag access is a level from the core
  wire unused_end = instr_end_in;
endmodule // smc_standby_ctrl
`default_nettype wire

// [bench/smc_standby_properties.sv]
// port assertions for the standby mode controller
`default_nettype none
module smc_standby_properties (
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] addr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        flag_access_in,
  input wire logic        irq_unmasked_in,
  input wire logic        nmi_in,
  input wire logic        global_irq_enable_in,
  input wire logic        timer_b_ext_sel_in,
  input wire logic        cpu_clk_en_out,
  input wire logic        osc_enable_out,
  input wire logic        latch_hold_out,
  input wire logic        irq_ack_allow_out,
  input wire logic        timer_b_run_out,
  input wire logic        resume_next_out,
  input wire logic        vector_irq_out,
  input wire logic        in_halt_out,
  input wire logic        in_stop_out,
  input wire logic        in_wait_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_halt_irq;
    in_halt_out && irq_unmasked_in && !nmi_in;
  endsequence
  AST_HALT_CLK: assert property (in_halt_out |-> !cpu_clk_en_out && osc_enable_out)
    else $error("halt lost oscillator or kept processor clock");
  AST_STOP_OSC: assert property (in_stop_out |-> !osc_enable_out && !cpu_clk_en_out)
    else $error("stop left oscillator running");
  AST_FLAG_HOLD: assert property (flag_access_in |-> !irq_ack_allow_out)
    else $error("interrupt allowed during flag access");
  AST_UPPER_ZERO: assert property (rd_in && addr_in == 16'hfffa |=> rdata_out[7:3] == 5'h00)
    else $error("upper select bits not zero");
  AST_HALT_NEXT: assert property (s_halt_irq ##0 !global_irq_enable_in |-> ##[1:4] resume_next_out)
    else $error("halt release without resume");
  AST_HALT_VEC: assert property (s_halt_irq ##0 global_irq_enable_in |-> ##[1:4] vector_irq_out)
    else $error("enabled halt release not vectored");
  AST_NMI_VEC: assert property (in_halt_out && nmi_in |-> ##[1:4] vector_irq_out)
    else $error("nmi did not vector");
  AST_LATCH: assert property (in_halt_out || in_stop_out |-> latch_hold_out)
    else $error("latches not held in standby");
  AST_WAIT_CPU: assert property (in_wait_out |-> !cpu_clk_en_out)
    else $error("processor ran during wait");
  AST_TIMER_B: assert property (!osc_enable_out |-> timer_b_run_out == timer_b_ext_sel_in)
    else $error("timer b gate wrong in stop");
endmodule // smc_standby_properties
bind smc_standby_ctrl smc_standby_properties chk_u (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .flag_access_in(flag_access_in),
  .irq_unmasked_in(irq_unmasked_in), .nmi_in(nmi_in),
  .global_irq_enable_in(global_irq_enable_in),
  .timer_b_ext_sel_in(timer_b_ext_sel_in), .cpu_clk_en_out(cpu_clk_en_out),
  .osc_enable_out(osc_enable_out), .latch_hold_out(latch_hold_out),
  .irq_ack_allow_out(irq_ack_allow_out), .timer_b_run_out(timer_b_run_out),
  .resume_next_out(resume_next_out), .vector_irq_out(vector_irq_out),
  .in_halt_out(in_halt_out), .in_stop_out(in_stop_out),
  .in_wait_out(in_wait_out));
`default_nettype wire

// [bench/smc_osc_model.sv]
// main oscillator model driven by the controller's enable
`default_nettype none
module smc_osc_model #(
  parameter logic [7:0] START_DLY = 8'h14
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic osc_enable_in,
  output var  logic osc_running_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  // start-up gap before oscillation, not part of the wait
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 8'h00;
      osc_running_out <= 1'b0;
    end else if (!osc_enable_in) begin
      cnt <= 8'h00;
      osc_running_out <= 1'b0;
    end else if (cnt == START_DLY) begin
      osc_running_out <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // smc_osc_model
`default_nettype wire

// [bench/smc_standby_ctrl_test.sv]
// self-checking bench for the standby mode controller
`default_nettype none
module smc_standby_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, halt = 0, stop = 0, fa = 0;
  logic irq = 0, nmi = 0, gie = 0, tsrc = 0, trun = 0, text = 0, sext = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  wire logic [7:0] rdata;
  wire logic osc_run, clk_en, osc_en, hold, ack, exti, ta, tb, ser;
  wire logic rnext, vec, ihalt, istop, iwait;
  int num_errors = 0, n_tests = 0, cnt;
  always #2.5 clk = ~clk;
  smc_osc_model osc_u (.ref_clk_in(clk), .rst_n_in(rst_n),
    .osc_enable_in(osc_en), .osc_running_out(osc_run));
  smc_standby_ctrl dut_u (.ref_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
    .halt_instr_in(halt), .stop_instr_in(stop), .flag_access_in(fa),
    .instr_end_in(1'b0), .irq_unmasked_in(irq), .nmi_in(nmi),
    .global_irq_enable_in(gie), .osc_running_in(osc_run),
    .timer_a_src_timer_b_in(tsrc), .timer_b_running_in(trun),
    .timer_b_ext_sel_in(text), .serial_ext_clk_in(sext),
    .cpu_clk_en_out(clk_en), .osc_enable_out(osc_en), .latch_hold_out(hold),
    .irq_ack_allow_out(ack), .ext_irq_enable_out(exti),
    .timer_a_run_out(ta), .timer_b_run_out(tb), .serial_run_out(ser),
    .resume_next_out(rnext), .vector_irq_out(vec), .in_halt_out(ihalt),
    .in_stop_out(istop), .in_wait_out(iwait));
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic wait_run(input int lim);
    cnt = 0;
    while (clk_en !== 1'b1 && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask
  task automatic osc_wait_run(input int lim);
    for (int k = 0; k < 100 && osc_run !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    wait_run(lim);
  endtask
  task automatic pulse(input bit s);
    @(posedge clk);
    if (s) stop <= 1'b1;
    else halt <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    halt <= 1'b0;
    #1;
  endtask
  task automatic halt_rel(input logic g, input logic n, input logic v);
    @(posedge clk);
    gie <= g;
    pulse(0);
    chk({ihalt, clk_en, osc_en, hold, exti}, 5'h16);
    @(posedge clk);
    irq <= ~n;
    nmi <= n;
    cnt = 0;
    while (!(rnext === 1'b1 || vec === 1'b1) && cnt < 8) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    chk({rnext, vec}, {~v, v});
    chk(cnt <= 4, 1'b1);
    @(posedge clk);
    irq <= 1'b0;
    nmi <= 1'b0;
    wait_run(8);
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(16'hfffa, 8'h04);
    osc_wait_run(40000);
    chk(cnt >= 32766 && cnt <= 32772, 1'b1);
    wr(16'hfffa, 8'hff);
    rd_chk(16'hfffa, 8'h07);
    rd_chk(16'hfff0, 8'h00);
    $display("register test done");
    halt_rel(1'b0, 1'b0, 1'b0);
    halt_rel(1'b1, 1'b0, 1'b1);
    halt_rel(1'b0, 1'b1, 1'b1);
    @(posedge clk);
    fa <= 1'b1;
    @(posedge clk);
    #1;
    chk(ack, 1'b0);
    @(posedge clk);
    fa <= 1'b0;
    irq <= 1'b1;
    pulse(0);
    wait_run(8);
    chk(clk_en, 1'b1);
    @(posedge clk);
    irq <= 1'b0;
    $display("halt test done");
    wr(16'hfffa, 8'h00);
    rd_chk(16'hfffa, 8'h00);
    pulse(1);
    chk({istop, osc_en, clk_en}, 3'h4);
    for (int j = 0; j < 3; j++) begin
      @(posedge clk);
      {tsrc, trun, text, sext} <= {j > 0, j > 1, j > 0, j > 0};
      @(posedge clk);
      #1;
      chk({ta, tb, ser, hold}, {j > 1, j > 0, j > 0, 1'b1});
    end
    @(posedge clk);
    irq <= 1'b1;
    osc_wait_run(5000);
    chk(cnt >= 4094 && cnt <= 4100, 1'b1);
    @(posedge clk);
    irq <= 1'b0;
    $display("stop test done");
    pulse(0);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk({ihalt, clk_en}, 2'h0);
    rst_n <= 1'b1;
    rd_chk(16'hfffa, 8'h04);
    chk({iwait, clk_en}, 2'h2);
    $display("reset test done");
    test_done();
  end
endmodule // smc_standby_ctrl_test
`default_nettype wire
